// >>> rtl/hbsa_arbiter.sv
/*
 * Host bus handover and suspend logic of the processor external port.
 * Assumes core/DMA access requests and bus lock come from logic on mclk_in;
 * host request, suspend, chip select and bus acknowledge are pins.
 */
`timescale 1ns/1ps
// Functional notes
// - Suspend plus request during a core access holds it until both are released.
// - Suspend plus request during DMA access: grant withheld until access ends.
// - Suspend plus request under bus lock floats the bus, no slave mode.
// - Only an unlocked core access may be suspended for host access.
// - Suspend after recognised request gives grant in the next cycle.
// - Request removal drops grant; suspended access restarts one cycle later.
// - A started DMA word runs to its acknowledge before bus handover.
// - Direct chip-select access completes via wait handshake without grant.
// - Suspend plus request during an unlocked core access puts the device in slave mode, access suspended.
// - Normal request is granted only after the current access completes.
module hbsa_arbiter
   import hbsa_pkg::*;
#(
   parameter logic [SLAVE_WAIT_W-1:0] SLAVE_WAIT = SLAVE_WAIT_CYC
) (
   input  wire logic mclk_in,
   input  wire logic rst_b_in,
   input  wire logic host_bus_request_n_in,
   input  wire logic suspend_bus_float_n_in,
   input  wire logic chip_select_n_in,
   input  wire logic bus_ack_in,
   input  wire logic access_start_in,
   input  wire logic access_is_dma_in,
   input  wire logic bus_lock_in,
   output logic      host_bus_grant_n_out,
   output logic      bus_hiz_out,
   output logic      slave_mode_out,
   output logic      access_suspended_out,
   output logic      access_restart_out,
   output logic      access_busy_out,
   output logic      host_wait_ack_out
);
   hbsa_sync_if #(.W(PIN_W)) pins ();

   hbsa_pin_sync #(.W(PIN_W)) u_sync (
      .mclk_in  (mclk_in),
      .rst_b_in (rst_b_in),
      .pins     (pins)
   );

   assign pins.raw = {bus_ack_in, chip_select_n_in, suspend_bus_float_n_in, host_bus_request_n_in};

   logic hbr_s, suspend_bus_float_n_s, cs_s, ack_s, susp_req;
   assign hbr_s    = !pins.lvl[PIN_HBR];
   assign suspend_bus_float_n_s   = !pins.lvl[PIN_SUSPEND_BUS_FLOAT_N];
   assign cs_s     = !pins.lvl[PIN_CS];
   assign ack_s    = pins.lvl[PIN_ACK];
   assign susp_req = hbr_s && suspend_bus_float_n_s;

   hbsa_state_t              st_q, st_d;
   logic                     dma_q, dma_d;
   logic                     grant_n_q, grant_n_d;
   logic                     hiz_q, hiz_d;
   logic                     slave_q, slave_d;
   logic                     susp_q, susp_d;
   logic                     restart_q, restart_d;
   logic                     busy_q, busy_d;
   logic                     wack_q, wack_d;
   logic [SLAVE_WAIT_W-1:0]  wcnt_q, wcnt_d;

   always_comb begin
      st_d      = st_q;
      dma_d     = dma_q;
      restart_d = 1'b0;
      unique case (st_q)
         ST_IDLE: begin
            if (hbr_s) begin
               st_d = ST_GRANT;
            end else if (access_start_in) begin
               st_d  = ST_ACC;
               dma_d = access_is_dma_in;
            end
         end
         ST_ACC: begin
            if (ack_s) begin
               st_d = ST_IDLE;
            end else if (susp_req) begin
               if (dma_q) begin
                  st_d = ST_ACC;
               end else if (bus_lock_in) begin
                  st_d = ST_FLOAT;
               end else begin
                  st_d = ST_SUSP;
               end
            end
         end
         ST_SUSP: begin
            if (!hbr_s && !suspend_bus_float_n_s) begin
               st_d = ST_REL;
            end
         end
         ST_REL: begin
            restart_d = 1'b1;
            st_d      = ST_ACC;
         end
         ST_GRANT: begin
            if (!hbr_s) begin
               st_d = ST_IDLE;
            end
         end
         ST_FLOAT: begin
            if (!hbr_s && !suspend_bus_float_n_s) begin
               st_d = ST_ACC;
            end
         end
      endcase
      grant_n_d = !(st_d == ST_SUSP || st_d == ST_GRANT);
      hiz_d     = (st_d == ST_SUSP || st_d == ST_GRANT || st_d == ST_FLOAT);
      slave_d   = (st_d == ST_SUSP || st_d == ST_GRANT);
      susp_d    = (st_d == ST_SUSP || st_d == ST_REL);
      busy_d    = (st_d == ST_ACC || st_d == ST_SUSP || st_d == ST_REL || st_d == ST_FLOAT);
   end

   // Direct slave access; served only while idle, granted or suspended
   always_comb begin
      wcnt_d = wcnt_q;
      wack_d = wack_q;
      if (!cs_s) begin
         wcnt_d = WAIT_ZERO;
         wack_d = 1'b0;
      end else if (st_q == ST_IDLE || st_q == ST_GRANT || st_q == ST_SUSP) begin
         if (wcnt_q + WAIT_ONE >= SLAVE_WAIT) begin
            wack_d = 1'b1;
         end else begin
            wcnt_d = wcnt_q + WAIT_ONE;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         st_q      <= ST_IDLE;
         dma_q     <= 1'b0;
         grant_n_q <= 1'b1;
         hiz_q     <= 1'b0;
         slave_q   <= 1'b0;
         susp_q    <= 1'b0;
         restart_q <= 1'b0;
         busy_q    <= 1'b0;
         wack_q    <= 1'b0;
         wcnt_q    <= WAIT_ZERO;
      end else begin
         st_q      <= st_d;
         dma_q     <= dma_d;
         grant_n_q <= grant_n_d;
         hiz_q     <= hiz_d;
         slave_q   <= slave_d;
         susp_q    <= susp_d;
         restart_q <= restart_d;
         busy_q    <= busy_d;
         wack_q    <= wack_d;
         wcnt_q    <= wcnt_d;
      end
   end

   assign host_bus_grant_n_out = grant_n_q;
   assign bus_hiz_out          = hiz_q;
   assign slave_mode_out       = slave_q;
   assign access_suspended_out = susp_q;
   assign access_restart_out   = restart_q;
   assign access_busy_out      = busy_q;
   assign host_wait_ack_out    = wack_q;

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);

   property p_hold_susp;
      (st_q == ST_SUSP) && (hbr_s || suspend_bus_float_n_s) |=> access_suspended_out && (st_q == ST_SUSP);
   endproperty
   a_hold_susp: assert property (p_hold_susp) else $error("suspended access released early");

   property p_dma_no_grant;
      (st_q == ST_ACC) && dma_q && susp_req |=> host_bus_grant_n_out;
   endproperty
   a_dma_no_grant: assert property (p_dma_no_grant) else $error("grant during dma access");

   property p_lock_float;
      (st_q == ST_ACC) && !dma_q && bus_lock_in && susp_req && !ack_s |=> bus_hiz_out && !slave_mode_out;
   endproperty
   a_lock_float: assert property (p_lock_float) else $error("bus lock float wrong");

   property p_core_only;
      $rose(access_suspended_out) |-> !$past(dma_q) && !$past(bus_lock_in);
   endproperty
   a_core_only: assert property (p_core_only) else $error("illegal suspend");

   property p_grant_next;
      (st_q == ST_ACC) && !dma_q && !bus_lock_in && susp_req && !ack_s |=> !host_bus_grant_n_out;
   endproperty
   a_grant_next: assert property (p_grant_next) else $error("grant not next cycle");

   property p_slave;
      (st_q == ST_ACC) && !dma_q && !bus_lock_in && susp_req && !ack_s |=> slave_mode_out && access_suspended_out;
   endproperty
   a_slave: assert property (p_slave) else $error("no slave mode on suspend");

   property p_restart;
      $rose(host_bus_grant_n_out) && access_suspended_out |=> access_restart_out ##1 !access_restart_out;
   endproperty
   a_restart: assert property (p_restart) else $error("restart not one cycle after grant");

   property p_dma_finish;
      (st_q == ST_ACC) && dma_q && !ack_s |=> access_busy_out && !bus_hiz_out;
   endproperty
   a_dma_finish: assert property (p_dma_finish) else $error("dma word broken");

   property p_normal;
      (st_q == ST_ACC) && hbr_s && !suspend_bus_float_n_s |=> host_bus_grant_n_out;
   endproperty
   a_normal: assert property (p_normal) else $error("grant during access");

   property p_hold_grant;
      !host_bus_grant_n_out && hbr_s |=> !host_bus_grant_n_out;
   endproperty
   a_hold_grant: assert property (p_hold_grant) else $error("grant dropped while requested");

   property p_direct;
      $rose(host_wait_ack_out) |-> $past(cs_s, 1) && !(st_q == ST_ACC && dma_q);
   endproperty
   a_direct: assert property (p_direct) else $error("wait ack without chip select");

   c_suspend: cover property ($rose(access_suspended_out) ##[1:50] access_restart_out);
   c_grant:   cover property ((st_q == ST_IDLE) && hbr_s ##1 !host_bus_grant_n_out);
   c_float:   cover property ($rose(bus_hiz_out) && !slave_mode_out);
   c_direct:  cover property ($rose(host_wait_ack_out) && host_bus_grant_n_out);
endmodule // hbsa_arbiter

// >>> rtl/hbsa_pin_sync.sv
/*
 * Three-flop pin synchroniser with agreement filter.
 * Assumes raw pins are asynchronous to mclk_in; a change is taken once
 * the second and third stages agree.
 */
`timescale 1ns/1ps
module hbsa_pin_sync
   import hbsa_pkg::*;
#(
   parameter int W = PIN_W
) (
   input  wire logic mclk_in,
   input  wire logic rst_b_in,
   hbsa_sync_if.sync pins
);
   logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
   logic [W-1:0] s1_d, s2_d, s3_d, lvl_d;

   always_comb begin
      s1_d  = pins.raw;
      s2_d  = s1_q;
      s3_d  = s2_q;
      // First stage is read only by the second stage
      lvl_d = lvl_q;
      for (int i = 0; i < W; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            lvl_d[i] = s3_q[i];
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         s1_q  <= PIN_IDLE;
         s2_q  <= PIN_IDLE;
         s3_q  <= PIN_IDLE;
         lvl_q <= PIN_IDLE;
      end else begin
         s1_q  <= s1_d;
         s2_q  <= s2_d;
         s3_q  <= s3_d;
         lvl_q <= lvl_d;
      end
   end

   assign pins.lvl = lvl_q;
endmodule // hbsa_pin_sync

// >>> rtl/hbsa_pkg.sv
/*
 * Shared constants for the host bus suspend arbiter: pin slots of the
 * synchroniser, idle pin levels, slave wait count and the arbiter states.
 * Assumes a single 20 MHz processor clock and a synchronous active-low reset.
 */
package hbsa_pkg;
   // Processor clock rate
   localparam int CLK_HZ = 20_000_000;

   // Slots of the synchronised pin vector
   localparam int PIN_W      = 4;
   localparam int PIN_HBR    = 0;
   localparam int PIN_SUSPEND_BUS_FLOAT_N   = 1;
   localparam int PIN_CS     = 2;
   localparam int PIN_ACK    = 3;
   // Active-low strobes idle high, bus acknowledge idles low
   localparam logic [PIN_W-1:0] PIN_IDLE = 4'h7;

   // Wait cycles before a direct slave access is acknowledged
   localparam int          SLAVE_WAIT_W   = 4;
   localparam logic [3:0]  SLAVE_WAIT_CYC = 4'h2;
   localparam logic [3:0]  WAIT_ZERO      = 4'h0;
   localparam logic [3:0]  WAIT_ONE       = 4'h1;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ACC,
      ST_SUSP,
      ST_REL,
      ST_GRANT,
      ST_FLOAT
   } hbsa_state_t;
endpackage

// >>> rtl/hbsa_sync_if.sv
/*
 * Carrier between the pin synchroniser and the arbiter core.
 * Assumes both ends run on the processor clock.
 */
`timescale 1ns/1ps
interface hbsa_sync_if #(
   parameter int W = 4
);
   logic [W-1:0] raw;
   logic [W-1:0] lvl;
   modport sync (input raw, output lvl);
   modport core (output raw, input lvl);
endinterface

// >>> sim/hbsa_host.sv
/*
 * Host pin model: bus request, suspend and chip select.
 * Assumes the bench calls its tasks just after a rising edge.
 */
`timescale 1ns/1ps
module hbsa_host (
   input  wire logic mclk_in,
   output logic      host_bus_request_n_out,
   output logic      suspend_bus_float_n_out,
   output logic      chip_select_n_out
);
   // Idle pins come from the same tasks the scenarios use
   initial begin
      select(1'b0);
      suspend(1'b0);
      request(1'b0);
   end

   // Suspend only under request; releasing it is always allowed
   task automatic suspend(input logic on);
      if (!on || !host_bus_request_n_out) begin
         suspend_bus_float_n_out = !on;
      end
   endtask

   // Suspend off an edge before request
   task automatic request(input logic on);
      if (!on && !suspend_bus_float_n_out) begin
         suspend_bus_float_n_out = 1'b1;
         @(posedge mclk_in);
         #1;
      end
      host_bus_request_n_out = !on;
   endtask

   task automatic select(input logic on);
      chip_select_n_out = !on;
   endtask
endmodule // hbsa_host

// >>> sim/test_hbsa_arbiter.sv
/*
 * Bench for the host bus suspend arbiter.
 * Assumes the bench plays core/DMA logic and bus acknowledge.
 */
`timescale 1ns/1ps
module test_hbsa_arbiter;
   import hbsa_pkg::*;
   logic mclk_in, rst_b_in, bus_ack_in, access_start_in, access_is_dma_in, bus_lock_in;
   logic req_n, susp_n, cs_n, grant_n, hiz, slave, susp, restart, busy, wack;
   int   mismatches;
   int   n_compared;

   hbsa_host i_hbsa_host (.mclk_in(mclk_in), .host_bus_request_n_out(req_n),
      .suspend_bus_float_n_out(susp_n), .chip_select_n_out(cs_n));
   hbsa_arbiter i_hbsa_arbiter (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
      .host_bus_request_n_in(req_n), .suspend_bus_float_n_in(susp_n),
      .chip_select_n_in(cs_n), .bus_ack_in(bus_ack_in), .access_start_in(access_start_in),
      .access_is_dma_in(access_is_dma_in), .bus_lock_in(bus_lock_in),
      .host_bus_grant_n_out(grant_n), .bus_hiz_out(hiz), .slave_mode_out(slave),
      .access_suspended_out(susp), .access_restart_out(restart),
      .access_busy_out(busy), .host_wait_ack_out(wack));

   initial begin
      mclk_in = 1'b0;
      forever #25 mclk_in = ~mclk_in;
   end

   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask

   task automatic chk(input logic got, input logic exp, input string what);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t %s", $time, what);
      end
   endtask

   function automatic logic pick(input int k);
      case (k)
         0: return grant_n;
         1: return hiz;
         2: return wack;
         default: return busy;
      endcase
   endfunction

   // Pin latency is several edges, so waits are bounded loosely
   task automatic wait_for(input int k, input logic v, input string what);
      for (int i = 0; i < 30 && pick(k) !== v; i++) step(1);
      n_compared++;
      if (pick(k) !== v) begin
         mismatches++;
         $display("BAD %0t timeout %s", $time, what);
         results();
      end
   endtask

   task automatic drive(input logic go, input logic dma, input logic lock, input logic done);
      access_start_in  = go;
      access_is_dma_in = dma;
      bus_lock_in      = lock;
      bus_ack_in       = done;
   endtask

   // Reset reloads the synchroniser with idle pins
   task automatic reset_pulse;
      rst_b_in = 1'b0;
      step(4);
      rst_b_in = 1'b1;
   endtask

   // Access starts only while the system bus is available
   task automatic start(input logic dma, input logic lock);
      drive(1'b1, dma, lock, 1'b0);
      step(1);
      drive(1'b0, dma, lock, 1'b0);
   endtask

   // Ack held until seen; its release needs the pin latency to clear
   task automatic ack;
      drive(1'b0, access_is_dma_in, bus_lock_in, 1'b1);
      wait_for(3, 1'b0, "access end");
      drive(1'b0, access_is_dma_in, bus_lock_in, 1'b0);
      step(6);
   endtask

   task automatic t_idle;
      i_hbsa_host.request(1'b1);
      wait_for(0, 1'b0, "idle grant");
      chk(slave, 1'b1, "slave");
      step(8);
      chk(grant_n, 1'b0, "grant held");
      i_hbsa_host.select(1'b1);
      wait_for(2, 1'b1, "access under grant");
      chk(grant_n, 1'b0, "grant during access");
      i_hbsa_host.select(1'b0);
      wait_for(2, 1'b0, "access end under grant");
      i_hbsa_host.request(1'b0);
      wait_for(0, 1'b1, "grant off");
      chk(slave, 1'b0, "slave off");
   endtask

   task automatic t_core;
      start(1'b0, 1'b0);
      chk(busy, 1'b1, "busy");
      i_hbsa_host.request(1'b1);
      step(8);
      chk(grant_n, 1'b1, "grant in access");
      i_hbsa_host.suspend(1'b1);
      wait_for(0, 1'b0, "suspend grant");
      chk(susp, 1'b1, "suspended");
      chk(slave, 1'b1, "slave");
      i_hbsa_host.request(1'b0);
      wait_for(0, 1'b1, "grant off");
      step(1);
      chk(restart, 1'b1, "restart");
      chk(busy, 1'b1, "resumed");
      ack();
   endtask

   task automatic t_dma;
      start(1'b1, 1'b0);
      i_hbsa_host.request(1'b1);
      step(8);
      i_hbsa_host.suspend(1'b1);
      step(12);
      chk(grant_n, 1'b1, "dma grant");
      chk(slave, 1'b0, "dma slave");
      chk(busy, 1'b1, "dma word held");
      // System side answers before the host lets go
      drive(1'b0, 1'b1, 1'b0, 1'b1);
      wait_for(0, 1'b0, "grant after dma");
      drive(1'b0, 1'b1, 1'b0, 1'b0);
      chk(busy, 1'b0, "dma done");
      step(1);
      start(1'b1, 1'b0);
      chk(busy, 1'b0, "next dma word held off");
      chk(grant_n, 1'b0, "grant kept over dma start");
      i_hbsa_host.request(1'b0);
      wait_for(0, 1'b1, "grant off");
      step(6);
   endtask

   task automatic t_lock;
      start(1'b0, 1'b1);
      i_hbsa_host.request(1'b1);
      step(8);
      i_hbsa_host.suspend(1'b1);
      wait_for(1, 1'b1, "float");
      step(3);
      chk(slave, 1'b0, "lock slave");
      chk(grant_n, 1'b1, "lock grant");
      i_hbsa_host.request(1'b0);
      wait_for(1, 1'b0, "unfloat");
      step(1);
      chk(restart, 1'b0, "no restart");
      ack();
      drive(1'b0, 1'b0, 1'b0, 1'b0);
      step(1);
   endtask

   // Reset in mid-suspend while the host keeps its pins asserted
   task automatic t_reset;
      start(1'b0, 1'b0);
      i_hbsa_host.request(1'b1);
      step(8);
      i_hbsa_host.suspend(1'b1);
      wait_for(0, 1'b0, "grant before reset");
      reset_pulse();
      chk(grant_n, 1'b1, "grant in reset");
      chk(busy, 1'b0, "busy in reset");
      chk(susp, 1'b0, "suspend in reset");
      step(1);
      chk(grant_n, 1'b1, "grant first edge");
      chk(hiz, 1'b0, "float first edge");
      wait_for(0, 1'b0, "grant after reset");
      chk(busy, 1'b0, "no access after reset");
      i_hbsa_host.request(1'b0);
      wait_for(0, 1'b1, "grant off after reset");
   endtask

   task automatic t_direct;
      i_hbsa_host.select(1'b1);
      wait_for(2, 1'b1, "ready");
      chk(grant_n, 1'b1, "no grant");
      i_hbsa_host.select(1'b0);
      wait_for(2, 1'b0, "ready off");
   endtask

   initial begin
      mismatches = 0;
      n_compared = 0;
      drive(1'b0, 1'b0, 1'b0, 1'b0);
      reset_pulse();
      chk(grant_n, 1'b1, "reset grant");
      chk(hiz, 1'b0, "reset float");
      step(6);
      t_idle();
      t_core();
      t_dma();
      t_lock();
      t_reset();
      t_direct();
      step(4);
      results();
   end
endmodule // test_hbsa_arbiter
